// *** rtl/gdsf_status.sv ***
// Supply fault status register with sticky event flags and a masked interrupt.
// Assumes comparator inputs and the configuration message strobe are synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "gdsf_regs.svh"
module gdsf_status
  import gdsf_pkg::*;
(
  input wire logic core_clk, // 250 MHz clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic clk_en, // Freezes all state while low
  input wire logic int_reset_evt, // Internal brown-out reset pulse
  input wire logic config_msg_rcvd, // Configuration message received pulse
  input wire logic ldo5_below_lockout, // 5 V regulator under lockout level
  input wire logic fet_vds_over_thresh, // Drain-source voltage above threshold
  input wire logic hs_gate_below_min, // Any high-side output under minimum drive
  input wire logic [3:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
  output logic irq // Level interrupt
);

  // ----------------------------------------------------------------
  // Status and interrupt state
  // ----------------------------------------------------------------
  gdsf_byte_t status_r, status_nxt;
  gdsf_byte_t status_rise;
  gdsf_byte_t irq_stat_r, irq_stat_nxt;
  gdsf_byte_t irq_mask_r, irq_mask_nxt;
  gdsf_byte_t rdata_r, rdata_nxt;
  logic wr_irq_stat;
  logic wr_irq_mask;

  // Address decode is shared by both writable registers, so it lives in one place.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] target,
                               input logic strobe);
    hit = strobe && (a == target);
  endfunction : hit

  function automatic gdsf_byte_t sel(input logic [3:0] a, input gdsf_byte_t s,
                                     input gdsf_byte_t i, input gdsf_byte_t m);
    case (a)
      `GDSF_ADDR_STATUS: sel = s;
      `GDSF_ADDR_IRQ_STAT: sel = i;
      `GDSF_ADDR_IRQ_MASK: sel = m;
      default: sel = 8'h00;
    endcase
  endfunction : sel

  // ----------------------------------------------------------------
  // Live and latched status flags
  // ----------------------------------------------------------------
  always_comb begin
    status_nxt = 8'h00;
    status_nxt[`GDSF_BIT_LDO5_UV] = ldo5_below_lockout;
    status_nxt[`GDSF_BIT_FET_OC] = fet_vds_over_thresh;
    status_nxt[`GDSF_BIT_GATE_UV] = hs_gate_below_min;
    // A reset arriving with a message wins, so a lost configuration is never hidden.
    if (int_reset_evt) begin
      status_nxt[`GDSF_BIT_CFG_LOST] = 1'b1;
    end else if (config_msg_rcvd) begin
      status_nxt[`GDSF_BIT_CFG_LOST] = 1'b0;
    end else begin
      status_nxt[`GDSF_BIT_CFG_LOST] = status_r[`GDSF_BIT_CFG_LOST];
    end
    status_rise = status_nxt & ~status_r & `GDSF_IMPL_MASK;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_r <= `GDSF_STATUS_RST;
    end else if (clk_en) begin
      status_r <= status_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    wr_irq_stat = hit(reg_addr, `GDSF_ADDR_IRQ_STAT, reg_wr);
    wr_irq_mask = hit(reg_addr, `GDSF_ADDR_IRQ_MASK, reg_wr);
    irq_stat_nxt = irq_stat_r;
    irq_mask_nxt = irq_mask_r;
    // Writes to the status address match no branch here and are dropped.
    if (wr_irq_stat) begin
      irq_stat_nxt = irq_stat_r & ~reg_wdata;
    end
    if (wr_irq_mask) begin
      irq_mask_nxt = reg_wdata & `GDSF_IMPL_MASK;
    end
    // The set is applied after the clear, so an event in the clearing cycle is never lost.
    irq_stat_nxt = irq_stat_nxt | status_rise;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= 8'h00;
      irq_mask_r <= `GDSF_IRQ_MASK_RST;
    end else if (clk_en) begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data returns to zero after its cycle so a stale value is never mistaken for a read.
  always_comb begin
    rdata_nxt = reg_rd ? sel(reg_addr, status_r, irq_stat_r, irq_mask_r) : 8'h00;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_unused_bits_zero: assert property (@(posedge core_clk) disable iff (rst)
    (status_r & ~`GDSF_IMPL_MASK) == 8'h00) else $error("Unused status bits set.");
  chk_ldo5_follows: assert property (@(posedge core_clk) disable iff (rst)
    clk_en |=> status_r[`GDSF_BIT_LDO5_UV] == $past(ldo5_below_lockout))
    else $error("Regulator flag does not follow input.");
  chk_cfg_lost_set: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && int_reset_evt |=> status_r[`GDSF_BIT_CFG_LOST]) else $error("Lost flag not set.");
  chk_cfg_lost_clear: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && config_msg_rcvd && !int_reset_evt |=> !status_r[`GDSF_BIT_CFG_LOST])
    else $error("Lost flag not cleared by message.");
  chk_cfg_lost_hold: assert property (@(posedge core_clk) disable iff (rst)
    !int_reset_evt && !config_msg_rcvd |=> $stable(status_r[`GDSF_BIT_CFG_LOST]))
    else $error("Lost flag changed without cause.");
  chk_reset_value: assert property (@(posedge core_clk)
    $fell(rst) |-> status_r == `GDSF_STATUS_RST) else $error("Wrong status reset value.");
  chk_fet_oc_follows: assert property (@(posedge core_clk) disable iff (rst)
    clk_en |=> status_r[`GDSF_BIT_FET_OC] == $past(fet_vds_over_thresh))
    else $error("Overcurrent flag does not follow input.");
  chk_gate_uv_follows: assert property (@(posedge core_clk) disable iff (rst)
    clk_en |=> status_r[`GDSF_BIT_GATE_UV] == $past(hs_gate_below_min))
    else $error("Gate drive flag does not follow input.");
  chk_status_read: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `GDSF_ADDR_STATUS |=> reg_rdata == $past(status_r))
    else $error("Status read returns wrong value.");
  chk_status_write_ignored: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == `GDSF_ADDR_STATUS && !int_reset_evt && !config_msg_rcvd
    |=> status_r[`GDSF_BIT_CFG_LOST] == $past(status_r[`GDSF_BIT_CFG_LOST]))
    else $error("Status write changed the lost flag.");
  chk_freeze_state: assert property (@(posedge core_clk) disable iff (rst)
    !clk_en |=> $stable(status_r) && $stable(irq_stat_r) && $stable(irq_mask_r)
    && $stable(reg_rdata))
    else $error("State changed while the clock enable was low.");
  chk_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data not zero outside a read.");
  chk_irq_stat_read: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `GDSF_ADDR_IRQ_STAT |=> reg_rdata == $past(irq_stat_r))
    else $error("Interrupt status read returns wrong value.");
  chk_mask_read: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `GDSF_ADDR_IRQ_MASK |=> reg_rdata == $past(irq_mask_r))
    else $error("Mask read returns wrong value.");
  chk_mask_write: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == `GDSF_ADDR_IRQ_MASK
    |=> irq_mask_r == ($past(reg_wdata) & `GDSF_IMPL_MASK))
    else $error("Mask write not taken.");
  chk_mask_hold: assert property (@(posedge core_clk) disable iff (rst)
    !(clk_en && reg_wr && reg_addr == `GDSF_ADDR_IRQ_MASK) |=> $stable(irq_mask_r))
    else $error("Mask changed without a write.");
  chk_w1c_clear: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == `GDSF_ADDR_IRQ_STAT
    |=> (irq_stat_r & $past(reg_wdata & ~status_rise)) == 8'h00)
    else $error("Write of one did not clear the interrupt status.");
  chk_set_wins: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && status_rise != 8'h00
    |=> (irq_stat_r & $past(status_rise)) == $past(status_rise))
    else $error("Status event lost from interrupt status.");
  chk_irq_unused_zero: assert property (@(posedge core_clk) disable iff (rst)
    ((irq_stat_r | irq_mask_r) & ~`GDSF_IMPL_MASK) == 8'h00)
    else $error("Unused interrupt bits set.");
endmodule : gdsf_status
`default_nettype wire

// *** rtl/gdsf_regs.svh ***
// Register offsets, field positions, reset values and the implemented-bit mask for the supply fault status block.
// Assumes inclusion by the status module and the bench only.
// Operation
// - Bits 7-6 and 1-0 of the status register always read as zero.
// - Bit 5 is one while the 5 V regulator is below its lockout level, else zero.
// - Bit 4 is set on any internal reset and stays set until the next configuration message.
// - After power-on reset bit 4 reads one and every other status bit reads zero.
// - Bit 3 is one while the transistor drain-source voltage exceeds the configured threshold.
// - Bit 2 is one while any high-side output is under the minimum gate drive level.
`ifndef GDSF_REGS_SVH
`define GDSF_REGS_SVH
`define GDSF_ADDR_STATUS 4'h0
`define GDSF_ADDR_IRQ_STAT 4'h1
`define GDSF_ADDR_IRQ_MASK 4'h2
`define GDSF_BIT_LDO5_UV 5
`define GDSF_BIT_CFG_LOST 4
`define GDSF_BIT_FET_OC 3
`define GDSF_BIT_GATE_UV 2
`define GDSF_STATUS_RST 8'h10
`define GDSF_IRQ_MASK_RST 8'h00
`define GDSF_IMPL_MASK 8'h3c
`endif

// *** rtl/gdsf_pkg.sv ***
// Types shared by the supply fault status block.
// Assumes the constants header sits beside it.
package gdsf_pkg;
  typedef logic [7:0] gdsf_byte_t;
endpackage : gdsf_pkg

// *** verif/gdsf_mcu_model.sv ***
// Companion controller model that sends configuration messages.
// Assumes send is a one-cycle request from the bench.
`timescale 1ns/1ps
`default_nettype none
module gdsf_mcu_model (
  input wire logic core_clk, // Clock
  input wire logic send, // Request one message
  output logic msg // One-cycle message strobe
);
  always_ff @(posedge core_clk) msg <= send;
endmodule : gdsf_mcu_model
`default_nettype wire

// *** verif/tb_gdsf_status.sv ***
// Self-checking bench for the supply fault status block.
// Assumes the controller model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "gdsf_regs.svh"
module tb_gdsf_status;
  import gdsf_pkg::*;
  logic core_clk = 0, rst = 1, evt = 0, send = 0, msg, ldo = 0, fet = 0, hs = 0;
  logic wr = 0, rd = 0, irq, en = 1, sc_en = 1;
  logic [3:0] ad = 0;
  gdsf_byte_t wd = 0, q;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  always #2 core_clk = ~core_clk;
  gdsf_mcu_model gdsf_mcu_model_inst (.core_clk(core_clk), .send(send), .msg(msg));
  gdsf_status gdsf_status_inst (.core_clk(core_clk), .rst(rst), .clk_en(en),
    .int_reset_evt(evt), .config_msg_rcvd(msg), .ldo5_below_lockout(ldo),
    .fet_vds_over_thresh(fet), .hs_gate_below_min(hs), .reg_addr(ad), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(q), .irq(irq));
  task chk(input gdsf_byte_t s, input gdsf_byte_t e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // One strobe per call; read data is looked at in its single valid cycle.
  task acc(input logic w, input logic [3:0] a, input gdsf_byte_t d);
    @(posedge core_clk);
    {wr, rd, ad, wd} <= {w, !w, a, d};
    @(posedge core_clk);
    {wr, rd} <= 2'b00;
    #1;
  endtask : acc
  task lv(input logic v);
    @(posedge core_clk);
    {ldo, fet, hs} <= {3{v}};
    repeat (3) @(posedge core_clk);
  endtask : lv
  task t_reset;
    acc(0, `GDSF_ADDR_STATUS, 0);
    chk(q, 8'h10);
    acc(1, `GDSF_ADDR_STATUS, 8'hff);
    acc(0, `GDSF_ADDR_STATUS, 0);
    chk(q, 8'h10);
  endtask : t_reset
  task t_lv_irq;
    lv(1);
    acc(0, `GDSF_ADDR_STATUS, 0);
    chk(q, 8'h3c);
    if (sc_en) chk({7'h0, q[`GDSF_BIT_FET_OC]}, 8'h01);
    chk({7'h0, irq}, 8'h00);
    acc(1, `GDSF_ADDR_IRQ_MASK, 8'h3c);
    chk({7'h0, irq}, 8'h01);
    lv(0);
    acc(1, `GDSF_ADDR_IRQ_STAT, 8'h3c);
    acc(0, `GDSF_ADDR_IRQ_STAT, 0);
    chk({q[7:1], irq}, 8'h00);
    acc(0, `GDSF_ADDR_STATUS, 0);
    chk(q, 8'h10);
  endtask : t_lv_irq
  task t_cfg;
    @(posedge core_clk);
    send <= 1;
    @(posedge core_clk);
    send <= 0;
    acc(0, `GDSF_ADDR_STATUS, 0);
    chk(q, 8'h00);
    @(posedge core_clk);
    evt <= 1;
    @(posedge core_clk);
    evt <= 0;
    repeat (2) @(posedge core_clk);
    acc(0, `GDSF_ADDR_STATUS, 0);
    chk(q, 8'h10);
    chk({7'h0, irq}, 8'h01);
  endtask : t_cfg
  task t_freeze;
    @(posedge core_clk);
    {en, ldo} <= 2'b01;
    repeat (3) @(posedge core_clk);
    {en, ldo} <= 2'b10;
    acc(0, `GDSF_ADDR_STATUS, 0);
    chk(q, 8'h10);
  endtask : t_freeze
  task t_both;
    @(posedge core_clk);
    send <= 1;
    @(posedge core_clk);
    send <= 0;
    repeat (2) @(posedge core_clk);
    send <= 1;
    @(posedge core_clk);
    {send, evt} <= 2'b01;
    @(posedge core_clk);
    evt <= 0;
    acc(0, `GDSF_ADDR_STATUS, 0);
    chk(q, 8'h10);
  endtask : t_both
  task stop_test;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 0;
    t_reset();
    t_lv_irq();
    t_cfg();
    t_freeze();
    t_both();
    stop_test();
  end
endmodule : tb_gdsf_status
`default_nettype wire
